// ==== dlclr_pkg.sv ====
// Package for the driver / launch / cable length register bank.
// Shared constants, field layouts and the serial-port state carrier.
package dlclr_pkg;

    localparam logic [6:0] ADDR_OUTPUT_DRIVER_CONTROL = 7'h01;
    localparam logic [6:0] ADDR_LAUNCH_AMPLITUDE_CONTROL = 7'h02;
    localparam logic [6:0] ADDR_CABLE_LENGTH_READOUT = 7'h06;

    localparam int SWING_MSB = 7;
    localparam int SWING_LSB = 6;
    localparam int OFFSET_MSB = 5;
    localparam int OFFSET_LSB = 4;
    localparam int DEEMPH_EN_BIT = 3;
    localparam int DEEMPH_LVL_MSB = 2;
    localparam int DEEMPH_LVL_LSB = 1;
    localparam int LAUNCH_BIT = 7;

    localparam logic [1:0] SWING_400MV = 2'h0;
    localparam logic [1:0] SWING_600MV = 2'h1;
    localparam logic [1:0] SWING_700MV = 2'h2;
    localparam logic [1:0] SWING_800MV = 2'h3;
    localparam logic [1:0] OFFSET_0V8 = 2'h0;
    localparam logic [1:0] OFFSET_1V0 = 2'h1;
    localparam logic [1:0] OFFSET_1V2 = 2'h2;
    localparam logic [1:0] OFFSET_SUPPLY_REF = 2'h3;
    localparam logic [1:0] DEEMPH_0DB = 2'h0;
    localparam logic [1:0] DEEMPH_3DB = 2'h1;
    localparam logic [1:0] DEEMPH_5DB = 2'h2;
    localparam logic [1:0] DEEMPH_7DB = 2'h3;

    // Reset values of the two writable registers (bit 0 of 01h reads zero)
    localparam logic [7:0] OUTPUT_DRIVER_RESET = 8'ha2;
    localparam logic [7:0] LAUNCH_AMPLITUDE_RESET = 8'h68;
    localparam logic [6:0] LAUNCH_RESERVED_VALUE = 7'h68;
    localparam logic [7:0] OUTPUT_DRIVER_WR_MASK = 8'hfe;

    localparam logic [7:0] CABLE_CODE_MAX = 8'hf7;
    localparam int FRAME_BITS = 16;
    localparam logic [15:0] READ_CMD_BIT = 16'h8000;

    typedef struct packed {
        logic [1:0] swing;
        logic [1:0] offset;
        logic deemph_en;
        logic [1:0] deemph_lvl;
        logic launch_atten;
    } dlclr_drv_cfg_t;

    typedef struct packed {
        logic [2:0] sck_sync;
        logic [1:0] ss_sync;
        logic [1:0] mosi_sync;
        logic ss_prev;
        logic [15:0] shift;
        logic miso;
        logic [7:0] out_drv;
        logic [7:0] launch;
        logic [7:0] cable_code;
        logic [4:0] bit_cnt;
    } dlclr_state_t;

endpackage

// ==== dlclr_regs.sv ====
// Serial register bank: output driver control, launch amplitude, cable length readout.
// Assumes a mode-0 serial host (sample on rising sck, shift on falling) and
// an adaptation engine on clk_sys_i that supplies the measured cable code.
// Function
// - Register 01h bits 7:6 hold swing, reset 10 meaning 700 mV.
// - Swing codes select 400, 600, 700 or 800 mV peak-to-peak.
// - Register 01h bits 5:4 hold offset, reset 10 meaning 1.2 V.
// - Offset codes below 11 step common mode 0.8 V to 1.2 V.
// - Offset code 11 references outputs to supply, about 1.35 V.
// - Register 01h bit 3 enables de-emphasis.
// - Register 01h bits 2:1 select de-emphasis of 0, 3, 5 or 7 dB.
// - De-emphasis codes ascend: 00 0 dB through 11 7 dB.
// - Register 02h bit 7 resets to 0, normal 800 mV launch.
// - Register 06h presents the 8-bit cable length code.
// - Cable length code never exceeds 247.
// - Cable code follows the equalizer continuously.
// - Writes take effect only when slave select rises after the frame.
`timescale 1ns/1ps
module dlclr_regs
    import dlclr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic spi_sck_i,
    input wire logic spi_ss_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    input wire logic [7:0] cable_length_code_i,
    output dlclr_drv_cfg_t drv_cfg_o,
    output logic [7:0] cable_length_code_o
);

    dlclr_state_t st_ff;
    dlclr_state_t nxt_st;
    dlclr_drv_cfg_t cfg_ff;
    dlclr_drv_cfg_t nxt_cfg;

    logic sck_rise;
    logic sck_fall;
    logic ss_rise;
    logic ss_low;
    logic [15:0] frame;
    logic [6:0] frm_addr;
    logic [7:0] read_data;

    always_comb
    begin
        sck_rise = st_ff.sck_sync[1] & ~st_ff.sck_sync[2];
        sck_fall = ~st_ff.sck_sync[1] & st_ff.sck_sync[2];
        ss_low = ~st_ff.ss_sync[1];
        ss_rise = st_ff.ss_sync[1] & ~st_ff.ss_prev;
        frame = st_ff.shift;
        frm_addr = frame[14:8];
        if (frm_addr == ADDR_OUTPUT_DRIVER_CONTROL)
        begin
            read_data = st_ff.out_drv;
        end
        else if (frm_addr == ADDR_LAUNCH_AMPLITUDE_CONTROL)
        begin
            read_data = st_ff.launch;
        end
        else if (frm_addr == ADDR_CABLE_LENGTH_READOUT)
        begin
            read_data = st_ff.cable_code;
        end
        else
        begin
            read_data = 8'h00;
        end
    end

    always_comb
    begin
        nxt_st = st_ff;
        // Sck sync is three deep: stage 0 is only read by stage 1
        nxt_st.sck_sync = {st_ff.sck_sync[1:0], spi_sck_i};
        nxt_st.ss_sync = {st_ff.ss_sync[0], spi_ss_n_i};
        nxt_st.mosi_sync = {st_ff.mosi_sync[0], spi_mosi_i};
        nxt_st.ss_prev = st_ff.ss_sync[1];

        // Saturate so an out-of-range adaptation result is never reported
        if (cable_length_code_i > CABLE_CODE_MAX)
        begin
            nxt_st.cable_code = CABLE_CODE_MAX;
        end
        else
        begin
            nxt_st.cable_code = cable_length_code_i;
        end

        if (ss_low)
        begin
            if (sck_rise)
            begin
                nxt_st.shift = {st_ff.shift[14:0], st_ff.mosi_sync[1]};
                if (st_ff.bit_cnt != 5'(FRAME_BITS))
                begin
                    nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
                end
            end
            if (sck_fall)
            begin
                // Daisy chain: previous frame contents leave msb first
                nxt_st.miso = st_ff.shift[15];
            end
        end
        else
        begin
            nxt_st.bit_cnt = 5'h00;
        end

        if (ss_rise)
        begin
            // Latch only on slave select release after a full 16-bit frame
            if (st_ff.bit_cnt == 5'(FRAME_BITS))
            begin
                if ((frame & READ_CMD_BIT) != 16'h0000)
                begin
                    nxt_st.shift = {frame[15:8], read_data};
                end
                else if (frm_addr == ADDR_OUTPUT_DRIVER_CONTROL)
                begin
                    nxt_st.out_drv = frame[7:0] & OUTPUT_DRIVER_WR_MASK;
                end
                else if (frm_addr == ADDR_LAUNCH_AMPLITUDE_CONTROL)
                begin
                    nxt_st.launch = {frame[LAUNCH_BIT], LAUNCH_RESERVED_VALUE};
                end
                // Cable length register has no write path
            end
            nxt_st.miso = nxt_st.shift[15];
        end
        nxt_cfg.swing = st_ff.out_drv[SWING_MSB:SWING_LSB];
        nxt_cfg.offset = st_ff.out_drv[OFFSET_MSB:OFFSET_LSB];
        nxt_cfg.deemph_en = st_ff.out_drv[DEEMPH_EN_BIT];
        nxt_cfg.deemph_lvl = st_ff.out_drv[DEEMPH_LVL_MSB:DEEMPH_LVL_LSB];
        nxt_cfg.launch_atten = st_ff.launch[LAUNCH_BIT];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            st_ff <= '0;
            st_ff.ss_sync <= 2'h3;
            st_ff.ss_prev <= 1'b1;
            st_ff.out_drv <= OUTPUT_DRIVER_RESET;
            st_ff.launch <= LAUNCH_AMPLITUDE_RESET;
            cfg_ff <= '0;
            cfg_ff.swing <= SWING_700MV;
            cfg_ff.offset <= OFFSET_1V2;
            cfg_ff.deemph_lvl <= DEEMPH_3DB;
        end
        else
        begin
            st_ff <= nxt_st;
            cfg_ff <= nxt_cfg;
        end
    end

    assign spi_miso_o = st_ff.miso;
    assign drv_cfg_o = cfg_ff;
    assign cable_length_code_o = st_ff.cable_code;

endmodule

// ==== dlclr_regs_asserts.sv ====
// Port checker for the register bank.
// Bound onto dlclr_regs; one clock domain.
`timescale 1ns/1ps
module dlclr_regs_asserts
    import dlclr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic spi_ss_n_i,
    input wire logic [7:0] cable_length_code_i,
    input wire dlclr_drv_cfg_t drv_cfg_o,
    input wire logic [7:0] cable_length_code_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    sequence s_ss_rise;
        $rose(spi_ss_n_i);
    endsequence
    AST_CODE_MAX: assert property (cable_length_code_o <= CABLE_CODE_MAX)
        else $error("cable code above ceiling");
    AST_CODE_TRACK: assert property (!$past(reset_i) |-> cable_length_code_o ==
        ($past(cable_length_code_i) > CABLE_CODE_MAX ? CABLE_CODE_MAX : $past(cable_length_code_i)))
        else $error("cable code not following input");
    AST_SWING_RST: assert property ($fell(reset_i) |-> drv_cfg_o.swing == SWING_700MV)
        else $error("swing reset wrong");
    AST_OFFSET_RST: assert property ($fell(reset_i) |-> drv_cfg_o.offset == OFFSET_1V2)
        else $error("offset reset wrong");
    AST_LAUNCH_RST: assert property ($fell(reset_i) |-> !drv_cfg_o.launch_atten)
        else $error("launch reset wrong");
    AST_NO_CHANGE_IN_FRAME: assert property (!spi_ss_n_i [*8] |-> $stable(drv_cfg_o))
        else $error("config moved inside a frame");
    AST_CHANGE_SS_HIGH: assert property ($changed(drv_cfg_o) |-> spi_ss_n_i)
        else $error("config moved with select low");
    AST_CFG_STANDS: assert property (s_ss_rise ##8 1 |-> $stable(drv_cfg_o) [*8])
        else $error("config moved after settling");
endmodule
bind dlclr_regs dlclr_regs_asserts i_dlclr_regs_asserts (.clk_sys_i, .reset_i, .spi_ss_n_i,
    .cable_length_code_i, .drv_cfg_o, .cable_length_code_o);

// ==== dlclr_host.sv ====
// Serial host model: mode 0, 80 ns sck period.
// Assumes clk_sys_i at 100 MHz paces the edges.
`timescale 1ns/1ps
module dlclr_host
(
    input wire logic clk_sys_i,
    input wire logic spi_miso_i,
    output logic spi_sck_o = 1'b0,
    output logic spi_ss_n_o = 1'b1,
    output logic spi_mosi_o = 1'b0
);
    // Host-side scaling of the cable code to centimetres of reference cable
    function automatic logic [31:0] code_to_cm(input logic [7:0] code, input logic sd);
        logic [31:0] c;
        c = {24'h000000, code};
        if (!sd)
        begin
            return c * 32'h0000007d;
        end
        else if (code <= 8'hbf)
        begin
            return c * 32'h0000007d - 32'h000007d0;
        end
        else
        begin
            return 32'h00005573 + (c - 32'h000000bf) * 32'h0000015e;
        end
    endfunction
    // Miso is read late in the high phase, well clear of its fall-edge update
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge clk_sys_i);
        spi_ss_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            spi_mosi_o <= tx[i];
            repeat (4) @(posedge clk_sys_i);
            spi_sck_o <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            rx[i] = spi_miso_i;
            spi_sck_o <= 1'b0;
        end
        repeat (4) @(posedge clk_sys_i);
        spi_ss_n_o <= 1'b1;
        // Undriven data line: show a changed level rather than the last bit
        spi_mosi_o <= ~tx[0];
        repeat (8) @(posedge clk_sys_i);
    endtask
endmodule

// ==== testbench.sv ====
// Bench: register reads and writes through the serial host model.
// Assumes dlclr_host drives the serial pins.
`timescale 1ns/1ps
module testbench;
    import dlclr_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic spi_sck_i, spi_ss_n_i, spi_mosi_i, spi_miso_o;
    logic [7:0] code_in = 8'h00;
    logic [7:0] code_out;
    logic [7:0] e;
    dlclr_drv_cfg_t cfg;
    logic [15:0] rx;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    dlclr_regs i_dlclr_regs (.clk_sys_i, .reset_i, .spi_sck_i, .spi_ss_n_i, .spi_mosi_i,
        .spi_miso_o, .cable_length_code_i(code_in), .drv_cfg_o(cfg), .cable_length_code_o(code_out));
    dlclr_host i_dlclr_host (.clk_sys_i, .spi_miso_i(spi_miso_o), .spi_sck_o(spi_sck_i),
        .spi_ss_n_o(spi_ss_n_i), .spi_mosi_o(spi_mosi_i));
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_dlclr_host.frame({1'b0, a, d}, rx);
    endtask
    // Read needs a second dummy frame to shift the answer out
    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string what);
        i_dlclr_host.frame({1'b1, a, 8'hff}, rx);
        i_dlclr_host.frame(16'hffff, rx);
        cmp8(what, exp, rx[7:0]);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        cmp8("cfg", 8'ha2, cfg);
        rd(ADDR_OUTPUT_DRIVER_CONTROL, OUTPUT_DRIVER_RESET, "reg01");
        rd(ADDR_LAUNCH_AMPLITUDE_CONTROL, LAUNCH_AMPLITUDE_RESET, "reg02");
        for (int i = 0; i < 4; i++)
        begin
            e = {i[1:0], i[1:0], i[0], i[1:0], 1'b0};
            wr(ADDR_OUTPUT_DRIVER_CONTROL, e | 8'h01);
            cmp8("cfg", e, cfg);
            rd(ADDR_OUTPUT_DRIVER_CONTROL, e, "reg01");
        end
        wr(ADDR_LAUNCH_AMPLITUDE_CONTROL, 8'h80);
        cmp8("cfg", 8'hff, cfg);
        rd(ADDR_LAUNCH_AMPLITUDE_CONTROL, 8'he8, "reg02");
        wr(ADDR_LAUNCH_AMPLITUDE_CONTROL, 8'h00);
        cmp8("cfg", 8'hfe, cfg);
        code_in <= 8'hff;
        wr(ADDR_CABLE_LENGTH_READOUT, 8'h00);
        rd(ADDR_CABLE_LENGTH_READOUT, CABLE_CODE_MAX, "reg06");
        cmp8("code", CABLE_CODE_MAX, code_out);
        cmp32("cm_hd", 32'h0000789b, i_dlclr_host.code_to_cm(rx[7:0], 1'b0));
        cmp32("cm_sd", 32'h0000a203, i_dlclr_host.code_to_cm(rx[7:0], 1'b1));
        cmp32("cm_sd_low", 32'h00002904, i_dlclr_host.code_to_cm(8'h64, 1'b1));
        code_in <= 8'hf6;
        rd(ADDR_CABLE_LENGTH_READOUT, 8'hf6, "reg06");
        cmp8("code", 8'hf6, code_out);
        cmp32("cm_sd", 32'h0000a0a5, i_dlclr_host.code_to_cm(rx[7:0], 1'b1));
        rd(7'h05, 8'h00, "unmapped");
        tally_and_finish();
    end
endmodule
